// ===== design/supply_readback_regs.sv
// register bank: supply fault mask, readback select, burst include mask
// assumes the frame logic presents decoded register requests on this clock
//
// Contract
// RULE1: a set supply mask bit keeps its status bit off the alert output.
// RULE2: status flags still set even when their mask bit is set.
// RULE3: mask has seven read/write bits 6..0; bits 15..7 read zero.
// RULE4: supply fault mask resets to zero.
// RULE5: eight-bit readback address names the register returned in reads.
// RULE6: auto read bit 9 returns readback data on every access.
// RULE7: select bit 8 low puts readback address 6..0 in frame bits 30..24.
// RULE8: select bit 8 high puts ready, alert and inputs in bits 30..24.
// RULE9: readback select resets to zero.
// RULE10: burst skips selectable registers whose include bit is zero.
// RULE11: include bits map alert, live, results, diagnostics, counter, supply.
// RULE12: burst include mask resets with all ten bits set.
// RULE13: registers without an include bit are always returned in a burst.
// RULE14: burst starting register is returned even if its bit is zero.
// RULE15: burst may start at comparator output, which cannot be skipped.
// RULE16: supply flags hold until written one after the fault has gone.
// RULE17: alert is any unmasked supply flag ORed with main alert sources.
// RULE18: upper bits order: ready, alert, inputs 3..0, then a zero.
`timescale 1ns/1ps
module supply_readback_regs
  import supply_readback_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register access from the frame logic
  input wire reg_req_t reg_req_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  // status sources
  input wire logic [6:0] supply_fault_level_in,
  input wire logic main_alert_in,
  input wire logic conversion_ready_in,
  input wire logic [3:0] digital_input_in,
  // readback frame control
  output readback_select_t frame_ctrl_out,
  output logic [6:0] frame_upper_out,
  // burst control
  input wire logic burst_start_in,
  input wire logic [7:0] burst_start_addr_in,
  input wire logic burst_next_in,
  output logic [7:0] burst_addr_out,
  // alert pin
  output logic alert_out
);

  logic [6:0] supply_fault_mask_r;
  readback_select_t readback_select_r;
  logic [9:0] burst_include_mask_r;
  logic [6:0] supply_status;
  logic [6:0] fault_seen;
  logic [6:0] status_clear;
  logic [15:0] rdata_nxt;
  logic [6:0] upper_nxt;

  function automatic logic wr_hit(input reg_req_t req, input logic [7:0] addr);
    return req.wr_en && (req.addr == addr);
  endfunction

  // true for registers that own an include bit
  function automatic logic selectable(input logic [7:0] addr);
    burst_slot_t s;
    s = burst_slot(addr);
    return s.valid;
  endfunction

  assign status_clear = wr_hit(reg_req_in, ADDR_SUPPLY_FAULT_STATUS) ? reg_req_in.wdata[6:0] : 7'h00;

  supply_fault_flags u_flags (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .fault_level_in(supply_fault_level_in),
    .clear_in(status_clear),
    .fault_seen_out(fault_seen),
    .status_out(supply_status)
  );

  burst_sequencer u_burst (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .start_in(burst_start_in),
    .start_addr_in(burst_start_addr_in),
    .next_in(burst_next_in),
    .include_in(burst_include_mask_r),
    .addr_out(burst_addr_out)
  );

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      supply_fault_mask_r <= SUPPLY_FAULT_MASK_RST; // [RULE4]
    end else if (wr_hit(reg_req_in, ADDR_SUPPLY_FAULT_MASK)) begin
      supply_fault_mask_r <= reg_req_in.wdata[6:0]; // [RULE3]
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      readback_select_r <= readback_select_t'(READBACK_SELECT_RST); // [RULE9]
    end else if (wr_hit(reg_req_in, ADDR_READBACK_SELECT)) begin
      readback_select_r <= readback_select_t'(reg_req_in.wdata[RBS_AUTO_READ_BIT:0]); // [RULE5]
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      burst_include_mask_r <= BURST_INCLUDE_RST; // [RULE12]
    end else if (wr_hit(reg_req_in, ADDR_BURST_INCLUDE_MASK)) begin
      burst_include_mask_r <= reg_req_in.wdata[9:0]; // [RULE11]
    end
  end

  // unmapped addresses and reserved bits read as zero
  always_comb begin
    rdata_nxt = 16'h0000;
    case (reg_req_in.addr)
      ADDR_SUPPLY_FAULT_STATUS: rdata_nxt = {9'h000, supply_status};
      ADDR_SUPPLY_FAULT_MASK: rdata_nxt = {9'h000, supply_fault_mask_r}; // [RULE3]
      ADDR_READBACK_SELECT: rdata_nxt = {6'h00, readback_select_r};
      ADDR_BURST_INCLUDE_MASK: rdata_nxt = {6'h00, burst_include_mask_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= READ_DATA_RST;
      reg_rdata_valid_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_req_in.rd_en ? rdata_nxt : reg_rdata_out;
      reg_rdata_valid_out <= reg_req_in.rd_en;
    end
  end

  // in status mode bit 24 stays zero: only six status flags exist for seven bits
  always_comb begin
    if (readback_select_r.frame_upper_bits_select) begin
      upper_nxt = {conversion_ready_in, alert_out, digital_input_in, 1'b0}; // [RULE8] [RULE18]
    end else begin
      upper_nxt = readback_select_r.readback_addr[6:0]; // [RULE7]
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      frame_upper_out <= FRAME_UPPER_RST;
      frame_ctrl_out <= readback_select_t'(READBACK_SELECT_RST);
    end else begin
      frame_upper_out <= upper_nxt;
      frame_ctrl_out <= readback_select_r; // [RULE5] [RULE6]
    end
  end

  // masking gates only the pin, the status flags are untouched
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      alert_out <= 1'b0;
    end else begin
      alert_out <= main_alert_in || (|(supply_status & ~supply_fault_mask_r)); // [RULE1] [RULE17]
    end
  end

  property p_mask_blocks_alert;
    @(posedge sys_clk_in) disable iff (rst_in)
      (!main_alert_in && ((supply_status & ~supply_fault_mask_r) == 7'h00)) |=> !alert_out;
  endproperty
  a_mask_blocks_alert: assert property (p_mask_blocks_alert) // [RULE1]
    else $error("masked supply flag drove the alert output");

  property p_unmasked_raises_alert;
    @(posedge sys_clk_in) disable iff (rst_in)
      (|(supply_status & ~supply_fault_mask_r)) |=> alert_out;
  endproperty
  a_unmasked_raises_alert: assert property (p_unmasked_raises_alert) // [RULE17]
    else $error("unmasked supply flag did not raise alert");

  property p_flag_sets_despite_mask;
    @(posedge sys_clk_in) disable iff (rst_in)
      fault_seen[FAULT_CAL_MEM_BIT] |=> supply_status[FAULT_CAL_MEM_BIT];
  endproperty
  a_flag_sets_despite_mask: assert property (p_flag_sets_despite_mask) // [RULE2]
    else $error("seen fault did not set its status flag");

  property p_mask_reserved_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
      (reg_req_in.rd_en && reg_req_in.addr == ADDR_SUPPLY_FAULT_MASK) |=>
        (reg_rdata_valid_out && reg_rdata_out[15:7] == 9'h000);
  endproperty
  a_mask_reserved_zero: assert property (p_mask_reserved_zero) // [RULE3]
    else $error("supply mask reserved bits read nonzero");

  property p_reset_values;
    @(posedge sys_clk_in) disable iff (rst_in)
      $fell(rst_in) |-> (supply_fault_mask_r == SUPPLY_FAULT_MASK_RST &&
        readback_select_r == readback_select_t'(READBACK_SELECT_RST) &&
        burst_include_mask_r == BURST_INCLUDE_RST);
  endproperty
  a_reset_values: assert property (p_reset_values) // [RULE4] [RULE9] [RULE12]
    else $error("register not at reset value after reset");

  property p_upper_holds_addr;
    @(posedge sys_clk_in) disable iff (rst_in)
      !readback_select_r.frame_upper_bits_select |=>
        frame_upper_out == $past(readback_select_r.readback_addr[6:0]);
  endproperty
  a_upper_holds_addr: assert property (p_upper_holds_addr) // [RULE7]
    else $error("frame upper bits do not carry readback address");

  property p_upper_holds_status;
    @(posedge sys_clk_in) disable iff (rst_in)
      readback_select_r.frame_upper_bits_select |=>
        frame_upper_out == $past({conversion_ready_in, alert_out, digital_input_in, 1'b0});
  endproperty
  a_upper_holds_status: assert property (p_upper_holds_status) // [RULE8]
    else $error("frame upper bits do not carry status flags");

  property p_auto_read_follows;
    @(posedge sys_clk_in) disable iff (rst_in)
      wr_hit(reg_req_in, ADDR_READBACK_SELECT) |=> ##1
        (frame_ctrl_out.auto_read_en == $past(reg_req_in.wdata[RBS_AUTO_READ_BIT], 2));
  endproperty
  a_auto_read_follows: assert property (p_auto_read_follows) // [RULE6]
    else $error("auto read enable not presented two cycles after write");

  property p_burst_start_taken;
    @(posedge sys_clk_in) disable iff (rst_in)
      burst_start_in |=> burst_addr_out == $past(burst_start_addr_in);
  endproperty
  a_burst_start_taken: assert property (p_burst_start_taken) // [RULE14]
    else $error("burst did not begin at its start address");

  property p_burst_never_lands_skipped;
    @(posedge sys_clk_in) disable iff (rst_in)
      (burst_next_in && !burst_start_in) |=>
        !burst_skipped(burst_addr_out, $past(burst_include_mask_r));
  endproperty
  a_burst_never_lands_skipped: assert property (p_burst_never_lands_skipped) // [RULE10]
    else $error("burst stepped onto a deselected register");

  property p_burst_keeps_unselectable;
    @(posedge sys_clk_in) disable iff (rst_in)
      (burst_next_in && !burst_start_in && !selectable(burst_addr_out + 8'h01)) |=>
        burst_addr_out == $past(burst_addr_out) + 8'h01;
  endproperty
  a_burst_keeps_unselectable: assert property (p_burst_keeps_unselectable) // [RULE13] [RULE15]
    else $error("burst skipped a register without an include bit");

  // writes land on the next edge, reads answer on the next edge
  property p_mask_write_lands;
    @(posedge sys_clk_in) disable iff (rst_in)
      wr_hit(reg_req_in, ADDR_SUPPLY_FAULT_MASK) |=> supply_fault_mask_r == $past(reg_req_in.wdata[6:0]);
  endproperty
  a_mask_write_lands: assert property (p_mask_write_lands) // [RULE3]
    else $error("supply mask write did not land");

  property p_select_write_lands;
    @(posedge sys_clk_in) disable iff (rst_in)
      wr_hit(reg_req_in, ADDR_READBACK_SELECT) |=>
        readback_select_r == $past(reg_req_in.wdata[RBS_AUTO_READ_BIT:0]);
  endproperty
  a_select_write_lands: assert property (p_select_write_lands) // [RULE5]
    else $error("readback select write did not land");

  property p_include_write_lands;
    @(posedge sys_clk_in) disable iff (rst_in)
      wr_hit(reg_req_in, ADDR_BURST_INCLUDE_MASK) |=> burst_include_mask_r == $past(reg_req_in.wdata[9:0]);
  endproperty
  a_include_write_lands: assert property (p_include_write_lands) // [RULE11]
    else $error("burst include write did not land");

  property p_include_reserved_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
      (reg_req_in.rd_en && reg_req_in.addr == ADDR_BURST_INCLUDE_MASK) |=> reg_rdata_out[15:10] == 6'h00;
  endproperty
  a_include_reserved_zero: assert property (p_include_reserved_zero) // [RULE11]
    else $error("burst include reserved bits read nonzero");

  property p_every_flag_sets;
    @(posedge sys_clk_in) disable iff (rst_in)
      (|fault_seen) |=> ((supply_status & $past(fault_seen)) == $past(fault_seen));
  endproperty
  a_every_flag_sets: assert property (p_every_flag_sets) // [RULE2]
    else $error("seen fault left its status flag clear");

  property p_status_reads_back;
    @(posedge sys_clk_in) disable iff (rst_in)
      (reg_req_in.rd_en && reg_req_in.addr == ADDR_SUPPLY_FAULT_STATUS) |=>
        reg_rdata_out == {9'h000, $past(supply_status)};
  endproperty
  a_status_reads_back: assert property (p_status_reads_back) // [RULE16]
    else $error("status read does not match the flags");

  property p_read_answers;
    @(posedge sys_clk_in) disable iff (rst_in)
      reg_req_in.rd_en |=> reg_rdata_valid_out;
  endproperty
  a_read_answers: assert property (p_read_answers) // [RULE5]
    else $error("read request got no answer strobe");

  property p_idle_holds_data;
    @(posedge sys_clk_in) disable iff (rst_in)
      !reg_req_in.rd_en |=> (!reg_rdata_valid_out && reg_rdata_out == $past(reg_rdata_out));
  endproperty
  a_idle_holds_data: assert property (p_idle_holds_data) // [RULE5]
    else $error("read data moved without a read request");

endmodule

// ===== design/supply_readback_pkg.sv
// package: register map, field positions, reset values and carriers
// assumes one 25 MHz clock domain shared by every user of these constants
package supply_readback_pkg;

  // register offsets
  localparam logic [7:0] ADDR_SUPPLY_FAULT_STATUS = 8'h5b;
  localparam logic [7:0] ADDR_SUPPLY_FAULT_MASK = 8'h60;
  localparam logic [7:0] ADDR_READBACK_SELECT = 8'h64;
  localparam logic [7:0] ADDR_BURST_INCLUDE_MASK = 8'h65;

  // selectable burst registers and the comparator output register
  localparam logic [7:0] ADDR_COMPARATOR_OUT = 8'h40;
  localparam logic [7:0] ADDR_ALERT_STATUS = 8'h41;
  localparam logic [7:0] ADDR_LIVE_STATE_FLAGS = 8'h42;
  localparam logic [7:0] ADDR_CONVERSION_RESULT_ONE = 8'h43;
  localparam logic [7:0] ADDR_CONVERSION_RESULT_TWO = 8'h44;
  localparam logic [7:0] ADDR_DIAGNOSTIC_RESULT_ZERO = 8'h45;
  localparam logic [7:0] ADDR_DIAGNOSTIC_RESULT_ONE = 8'h46;
  localparam logic [7:0] ADDR_DIAGNOSTIC_RESULT_TWO = 8'h47;
  localparam logic [7:0] ADDR_DIAGNOSTIC_RESULT_THREE = 8'h48;
  localparam logic [7:0] ADDR_INPUT_COUNTER = 8'h49;

  // field widths and positions
  localparam int SUPPLY_BITS = 7;
  localparam int BURST_BITS = 10;
  localparam int FRAME_UPPER_BITS = 7;
  localparam int FAULT_CAL_MEM_BIT = 6;
  localparam int FAULT_DRIVER_SUPPLY_BIT = 5;
  localparam int FAULT_REGULATOR_1V8_BIT = 4;
  localparam int FAULT_ANALOG_CORE_BIT = 3;
  localparam int FAULT_DIGITAL_SUPPLY_BIT = 2;
  localparam int FAULT_NEGATIVE_ANALOG_BIT = 1;
  localparam int FAULT_POSITIVE_ANALOG_BIT = 0;
  localparam int RBS_AUTO_READ_BIT = 9;
  localparam int RBS_UPPER_SELECT_BIT = 8;
  localparam int RBS_ADDR_MSB = 7;

  // values after reset
  localparam logic [6:0] SUPPLY_FAULT_MASK_RST = 7'h00;
  localparam logic [6:0] SUPPLY_FAULT_STATUS_RST = 7'h00;
  localparam logic [9:0] READBACK_SELECT_RST = 10'h000;
  localparam logic [9:0] BURST_INCLUDE_RST = 10'h3ff;
  localparam logic [7:0] BURST_ADDR_RST = 8'h00;
  localparam logic [15:0] READ_DATA_RST = 16'h0000;
  localparam logic [6:0] FRAME_UPPER_RST = 7'h00;

  // longest run of skippable registers is nine, so eleven steps always land
  localparam int BURST_SEARCH_STEPS = 11;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic auto_read_en;
    logic frame_upper_bits_select;
    logic [7:0] readback_addr;
  } readback_select_t;

  typedef struct packed {
    logic valid;
    logic [3:0] index;
  } burst_slot_t;

  function automatic burst_slot_t burst_slot(input logic [7:0] addr);
    burst_slot_t s;
    s = '{valid: 1'b1, index: 4'h0};
    case (addr)
      ADDR_ALERT_STATUS: s.index = 4'h0;
      ADDR_LIVE_STATE_FLAGS: s.index = 4'h1;
      ADDR_CONVERSION_RESULT_ONE: s.index = 4'h2;
      ADDR_CONVERSION_RESULT_TWO: s.index = 4'h3;
      ADDR_DIAGNOSTIC_RESULT_ZERO: s.index = 4'h4;
      ADDR_DIAGNOSTIC_RESULT_ONE: s.index = 4'h5;
      ADDR_DIAGNOSTIC_RESULT_TWO: s.index = 4'h6;
      ADDR_DIAGNOSTIC_RESULT_THREE: s.index = 4'h7;
      ADDR_INPUT_COUNTER: s.index = 4'h8;
      ADDR_SUPPLY_FAULT_STATUS: s.index = 4'h9;
      default: s.valid = 1'b0;
    endcase
    return s;
  endfunction

  function automatic logic burst_skipped(input logic [7:0] addr, input logic [9:0] incl_mask);
    burst_slot_t s;
    s = burst_slot(addr);
    return s.valid && !incl_mask[s.index];
  endfunction

endpackage

// ===== design/supply_fault_flags.sv
// sticky supply fault flags with write-one-to-clear
// assumes fault levels arrive asynchronously from the supply monitors
`timescale 1ns/1ps
module supply_fault_flags
  import supply_readback_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // monitor side
  input wire logic [6:0] fault_level_in,
  // software clear, one-cycle pulse per bit
  input wire logic [6:0] clear_in,
  // results
  output logic [6:0] fault_seen_out,
  output logic [6:0] status_out
);

  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic [6:0] sync3_r;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync1_r <= SUPPLY_FAULT_STATUS_RST;
      sync2_r <= SUPPLY_FAULT_STATUS_RST;
      sync3_r <= SUPPLY_FAULT_STATUS_RST;
    end else begin
      sync1_r <= fault_level_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a level counts only once the last two stages agree
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fault_seen_out <= SUPPLY_FAULT_STATUS_RST;
    end else begin
      for (int i = 0; i < SUPPLY_BITS; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          fault_seen_out[i] <= sync3_r[i];
        end
      end
    end
  end

  // set wins over clear, so a live fault cannot be wiped
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      status_out <= SUPPLY_FAULT_STATUS_RST;
    end else begin
      status_out <= fault_seen_out | (status_out & ~clear_in); // [RULE2] [RULE16]
    end
  end

  property p_clear_blocked_while_fault;
    @(posedge sys_clk_in) disable iff (rst_in)
      (fault_seen_out[0] && clear_in[0]) |=> status_out[0];
  endproperty
  a_clear_blocked_while_fault: assert property (p_clear_blocked_while_fault) // [RULE16]
    else $error("supply flag cleared while its fault was present");

endmodule

// ===== design/burst_sequencer.sv
// burst read address stepper that skips deselected registers
// assumes start and next strobes come from the frame logic on the same clock
`timescale 1ns/1ps
module burst_sequencer
  import supply_readback_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // burst control
  input wire logic start_in,
  input wire logic [7:0] start_addr_in,
  input wire logic next_in,
  input wire logic [9:0] include_in,
  // current address
  output logic [7:0] addr_out
);

  function automatic logic [7:0] next_included(input logic [7:0] cur, input logic [9:0] incl_mask);
    logic [7:0] cand;
    logic found;
    cand = cur;
    found = 1'b0;
    for (int i = 1; i <= BURST_SEARCH_STEPS; i++) begin
      if (!found) begin
        cand = cur + 8'(i);
        found = !burst_skipped(cand, incl_mask); // [RULE10] [RULE13]
      end
    end
    return cand;
  endfunction

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      addr_out <= BURST_ADDR_RST;
    end else if (start_in) begin
      // start address always taken, selected or not
      addr_out <= start_addr_in; // [RULE14] [RULE15]
    end else if (next_in) begin
      addr_out <= next_included(addr_out, include_in);
    end
  end

endmodule

// ===== bench/spi_host_model.sv
// host-side model: issues register requests and burst strobes to the bank
// assumes the bank takes requests on the rising edge and answers one cycle later
`timescale 1ns/1ps
module spi_host_model
  import supply_readback_pkg::*;
(
  // clock
  input wire logic sys_clk_in,
  // read answer from the bank
  input wire logic [15:0] reg_rdata_in,
  input wire logic reg_rdata_valid_in,
  // requests to the bank
  output reg_req_t reg_req_out,
  output logic burst_start_out,
  output logic [7:0] burst_start_addr_out,
  output logic burst_next_out
);
  initial begin
    reg_req_out = '0;
    burst_start_out = 1'b0;
    burst_start_addr_out = 8'h00;
    burst_next_out = 1'b0;
  end

  // idle address and data are inverted so a stale value is never mistaken for a live one
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_req_out <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_in);
    reg_req_out <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge sys_clk_in);
    reg_req_out <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk_in);
    reg_req_out <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 16'hffff};
    // answer strobe stands for one cycle only, so look inside that cycle
    @(negedge sys_clk_in);
    ok = reg_rdata_valid_in;
    d = reg_rdata_in;
  endtask

  // a start names its address; a next only advances
  task automatic burst_step(input logic s, input logic [7:0] a);
    @(posedge sys_clk_in);
    burst_start_out <= s;
    burst_next_out <= !s;
    burst_start_addr_out <= a;
    @(posedge sys_clk_in);
    burst_start_out <= 1'b0;
    burst_next_out <= 1'b0;
    burst_start_addr_out <= ~a;
  endtask
endmodule

// ===== bench/supply_readback_regs_bench.sv
// self-checking bench for the supply mask, readback select and burst include bank
// assumes the host model drives all requests; fault levels and status inputs come from here
`timescale 1ns/1ps
module supply_readback_regs_bench;
  import supply_readback_pkg::*;

  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  reg_req_t reg_req;
  logic [15:0] reg_rdata;
  logic reg_rdata_valid;
  logic [6:0] supply_fault_level = 7'h00;
  logic main_alert = 1'b0;
  logic conversion_ready = 1'b0;
  logic [3:0] digital_input = 4'h0;
  readback_select_t frame_ctrl;
  logic [6:0] frame_upper;
  logic burst_start;
  logic [7:0] burst_start_addr;
  logic burst_next;
  logic [7:0] burst_addr;
  logic alert;
  int failures = 0;
  int comparisons = 0;
  logic [7:0] slots [10] = '{ADDR_ALERT_STATUS, ADDR_LIVE_STATE_FLAGS, ADDR_CONVERSION_RESULT_ONE,
    ADDR_CONVERSION_RESULT_TWO, ADDR_DIAGNOSTIC_RESULT_ZERO, ADDR_DIAGNOSTIC_RESULT_ONE,
    ADDR_DIAGNOSTIC_RESULT_TWO, ADDR_DIAGNOSTIC_RESULT_THREE, ADDR_INPUT_COUNTER, ADDR_SUPPLY_FAULT_STATUS};

  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  supply_readback_regs dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_req_in(reg_req), .reg_rdata_out(reg_rdata),
    .reg_rdata_valid_out(reg_rdata_valid), .supply_fault_level_in(supply_fault_level),
    .main_alert_in(main_alert), .conversion_ready_in(conversion_ready), .digital_input_in(digital_input),
    .frame_ctrl_out(frame_ctrl), .frame_upper_out(frame_upper), .burst_start_in(burst_start),
    .burst_start_addr_in(burst_start_addr), .burst_next_in(burst_next), .burst_addr_out(burst_addr),
    .alert_out(alert));

  spi_host_model host (
    .sys_clk_in(sys_clk_in), .reg_rdata_in(reg_rdata), .reg_rdata_valid_in(reg_rdata_valid),
    .reg_req_out(reg_req), .burst_start_out(burst_start), .burst_start_addr_out(burst_start_addr),
    .burst_next_out(burst_next));

  task automatic finish_test();
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic expect_reg(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host.reg_read(a, d, ok);
    check_flag({what, " valid"}, 1'b1, ok);
    check_word(what, exp, d);
  endtask

  task automatic expect_burst(input string what, input logic s, input logic [7:0] a, input logic [7:0] exp);
    host.burst_step(s, a);
    @(negedge sys_clk_in);
    check_word(what, {8'h00, exp}, {8'h00, burst_addr});
  endtask

  // frame outputs trail a readback select write by two cycles
  task automatic expect_frame(input logic [15:0] w, input logic [9:0] exp_ctrl, input logic [6:0] exp_up);
    host.reg_write(ADDR_READBACK_SELECT, w);
    repeat (2) @(negedge sys_clk_in);
    check_word("frame_ctrl", {6'h00, exp_ctrl}, {6'h00, frame_ctrl});
    check_word("frame_upper", {9'h000, exp_up}, {9'h000, frame_upper});
  endtask

  initial begin
    #(40 * 20000);
    failures++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    expect_reg("mask reset", ADDR_SUPPLY_FAULT_MASK, 16'h0000);
    expect_reg("select reset", ADDR_READBACK_SELECT, 16'h0000);
    expect_reg("include reset", ADDR_BURST_INCLUDE_MASK, 16'h03ff);
    expect_reg("unmapped", 8'h70, 16'h0000);
    host.reg_write(ADDR_SUPPLY_FAULT_MASK, 16'hffff);
    expect_reg("mask width", ADDR_SUPPLY_FAULT_MASK, 16'h007f);
    // masked fault: flag sets, pin stays quiet
    host.reg_write(ADDR_SUPPLY_FAULT_MASK, 16'h0004);
    @(posedge sys_clk_in) supply_fault_level <= 7'h04;
    repeat (10) @(negedge sys_clk_in);
    check_flag("alert masked", 1'b0, alert);
    expect_reg("status masked", ADDR_SUPPLY_FAULT_STATUS, 16'h0004);
    host.reg_write(ADDR_SUPPLY_FAULT_MASK, 16'h0000);
    repeat (3) @(negedge sys_clk_in);
    check_flag("alert unmasked", 1'b1, alert);
    // clearing while the fault persists must not drop the flag
    host.reg_write(ADDR_SUPPLY_FAULT_STATUS, 16'h0004);
    expect_reg("status held", ADDR_SUPPLY_FAULT_STATUS, 16'h0004);
    @(posedge sys_clk_in) supply_fault_level <= 7'h00;
    repeat (10) @(negedge sys_clk_in);
    expect_reg("status sticky", ADDR_SUPPLY_FAULT_STATUS, 16'h0004);
    host.reg_write(ADDR_SUPPLY_FAULT_STATUS, 16'h0004);
    expect_reg("status cleared", ADDR_SUPPLY_FAULT_STATUS, 16'h0000);
    repeat (2) @(negedge sys_clk_in);
    check_flag("alert cleared", 1'b0, alert);
    @(posedge sys_clk_in) main_alert <= 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check_flag("alert main", 1'b1, alert);
    @(posedge sys_clk_in) main_alert <= 1'b0;
    repeat (2) @(negedge sys_clk_in);
    // address mode keeps only the low seven address bits
    expect_frame(16'h02d5, 10'h2d5, 7'h55);
    expect_reg("select readback", ADDR_READBACK_SELECT, 16'h02d5);
    @(posedge sys_clk_in) begin
      conversion_ready <= 1'b1;
      digital_input <= 4'ha;
    end
    expect_frame(16'h0100, 10'h100, {1'b1, 1'b0, 4'ha, 1'b0});
    // one deselected slot at a time, stepping over it from the address below
    for (int i = 0; i < 10; i++) begin
      host.reg_write(ADDR_BURST_INCLUDE_MASK, 16'h03ff ^ (16'h0001 << i));
      expect_burst("burst start", 1'b1, slots[i] - 8'h01, slots[i] - 8'h01);
      expect_burst("burst skip", 1'b0, 8'h00, slots[i] + 8'h01);
    end
    host.reg_write(ADDR_BURST_INCLUDE_MASK, 16'h0000);
    expect_burst("start deselected", 1'b1, ADDR_ALERT_STATUS, ADDR_ALERT_STATUS);
    expect_burst("skip run", 1'b0, 8'h00, 8'h4a);
    expect_burst("comparator start", 1'b1, ADDR_COMPARATOR_OUT, ADDR_COMPARATOR_OUT);
    expect_burst("skip all", 1'b0, 8'h00, 8'h4a);
    expect_burst("unselectable", 1'b0, 8'h00, 8'h4b);
    finish_test();
  end
endmodule
